/* File: hw/trb_cfg.svh */
// Command codes, formats and reset values of the telemetry readback bank
`ifndef TRB_CFG_SVH
`define TRB_CFG_SVH
`define TRB_CMD_VIN        8'h88
`define TRB_CMD_IIN        8'h89
`define TRB_CMD_VOUT       8'h8b
`define TRB_CMD_IOUT       8'h8c
`define TRB_CMD_TSTAGE     8'h8d
`define TRB_CMD_TDIE       8'h8e
`define TRB_CMD_DUTY       8'h94
`define TRB_CMD_POUT       8'h96
`define TRB_CMD_IOUT_PK    8'hd7
`define TRB_CMD_SEL        8'hd8
`define TRB_CMD_VOUT_PK    8'hdd
`define TRB_CMD_VIN_PK     8'hde
`define TRB_CMD_TSTAGE_PK  8'hdf
`define TRB_CMD_IIN_CH     8'hed
`define TRB_CMD_TDIE_PK    8'hf4
`define TRB_SEL_RST        8'h00
`define TRB_SEL_RR         8'h00
`define TRB_SEL_VIN        8'h01
`define TRB_SEL_DIE        8'h04
`define TRB_SEL_VO0        8'h05
`define TRB_SEL_IO0        8'h06
`define TRB_SEL_TS0        8'h08
`define TRB_SEL_VO1        8'h09
`define TRB_SEL_IO1        8'h0a
`define TRB_SEL_TS1        8'h0c
`define TRB_SEL_SHORT      8'h0d
`define TRB_EXP_VIN        5'h1a
`define TRB_EXP_TEMP       5'h00
`define TRB_EXP_IOUT       5'h1c
`define TRB_EXP_DUTY       5'h00
`define TRB_EXP_POUT_ADJ   5'h10
`define TRB_TEMP_SHIFT     10
`define TRB_TC_SHIFT       10
`define TRB_IOUT_SHIFT     12
`define TRB_DUTY_SHIFT     8
`define TRB_POUT_SHIFT     16
`define TRB_TEMP_REF       11'sd25
`define TRB_DUTY_PCT       9'd100
`define TRB_L11_MIN        11'h400
`endif

/* File: hw/trb_pkg.sv */
// Types of the telemetry readback bank
package trb_pkg;
    typedef enum logic [2:0] {
        TRB_VIN, TRB_DIE, TRB_VO0, TRB_IO0,
        TRB_TS0, TRB_VO1, TRB_IO1, TRB_TS1
    } trb_param_e;
    typedef logic [10:0] trb_mant_t;
endpackage : trb_pkg

/* File: hw/trb_telemetry_bank.sv */
// Telemetry readback bank: conversion scheduling, derived values, peaks, read mux
`timescale 1ns/1ps
`include "trb_cfg.svh"
module trb_telemetry_bank (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                page_i,
    input  wire logic [7:0]          cmd_i,
    input  wire logic                rd_start_i,
    input  wire logic                byte_rd_i,
    input  wire logic                wr_byte_i,
    input  wire logic [7:0]          wr_data_i,
    input  wire logic                peak_clr_i,
    input  wire logic [3:0]          flag_clr_i,
    input  wire logic                conv_done_i,
    input  wire logic [15:0]         conv_data_i,
    input  wire logic [4:0]          vout_exp_i,
    input  wire logic [1:0][7:0]     duty_i,
    input  wire logic [1:0][15:0]    cs_gain_i,
    input  wire logic [1:0][15:0]    gain_tc_i,
    input  wire logic [1:0][15:0]    temp_gain_i,
    input  wire logic [1:0][10:0]    temp_off_i,
    input  wire logic [1:0][10:0]    iin_off_i,
    output trb_pkg::trb_param_e      conv_sel_o,
    output logic [7:0]               rd_byte_o,
    output logic                     cmd_err_o,
    output logic [3:0]               flags_o,
    output logic                     cml_fault_o
);
    import trb_pkg::*;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0]       sel_r;
    logic [2:0]       rr_r;
    logic [1:0]       srr_r;
    trb_mant_t        vin_r;
    trb_mant_t        die_r;
    trb_mant_t        vin_pk_r;
    trb_mant_t        die_pk_r;
    logic [15:0]      word_r;
    logic             hi_r;
    logic             one_r;
    logic [1:0][15:0] vout_r;
    logic [1:0][15:0] vout_pk_r;
    logic [1:0][15:0] vcor_r;
    trb_mant_t [1:0]  iout_r;
    trb_mant_t [1:0]  iout_pk_r;
    trb_mant_t [1:0]  icor_r;
    trb_mant_t [1:0]  temp_r;
    trb_mant_t [1:0]  temp_pk_r;
    logic [1:0][7:0]  duty_r;
    trb_mant_t [1:0]  iin_ch;
    trb_mant_t [1:0]  pout_ch;
    trb_mant_t [1:0]  iout_new;
    trb_mant_t [1:0]  temp_new;
    logic [1:0][6:0]  duty_pct;
    trb_mant_t        iin_tot;
    logic [4:0]       pout_exp;
    logic             sel_bad;
    logic             take;
    trb_param_e       next_sel;
    logic [15:0]      word_nxt;
    logic             known;
    logic [3:0]       flag_hit;

    assign take = ce_i && conv_done_i;

    // ----------------------------------------
    // Select byte
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_r <= `TRB_SEL_RST;
        end else if (ce_i && wr_byte_i && cmd_i == `TRB_CMD_SEL) begin
            sel_r <= wr_data_i;
        end
    end

    always_comb begin
        unique case (sel_r)
            `TRB_SEL_RR, `TRB_SEL_VIN, `TRB_SEL_DIE, `TRB_SEL_VO0, `TRB_SEL_IO0,
            `TRB_SEL_TS0, `TRB_SEL_VO1, `TRB_SEL_IO1, `TRB_SEL_TS1,
            `TRB_SEL_SHORT: sel_bad = 1'b0;
            default:        sel_bad = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cml_fault_o <= 1'b0;
        end else if (ce_i) begin
            cml_fault_o <= sel_bad;
        end
    end

    // ----------------------------------------
    // Conversion scheduling
    // ----------------------------------------
    always_comb begin
        unique case (sel_r)
            `TRB_SEL_RR:    next_sel = trb_param_e'(rr_r + 3'd1);
            `TRB_SEL_VIN:   next_sel = TRB_VIN;
            `TRB_SEL_DIE:   next_sel = TRB_DIE;
            `TRB_SEL_VO0:   next_sel = TRB_VO0;
            `TRB_SEL_IO0:   next_sel = TRB_IO0;
            `TRB_SEL_TS0:   next_sel = TRB_TS0;
            `TRB_SEL_VO1:   next_sel = TRB_VO1;
            `TRB_SEL_IO1:   next_sel = TRB_IO1;
            `TRB_SEL_TS1:   next_sel = TRB_TS1;
            `TRB_SEL_SHORT: begin
                unique case (srr_r + 2'd1)
                    2'd0:    next_sel = TRB_VO0;
                    2'd1:    next_sel = TRB_IO0;
                    2'd2:    next_sel = TRB_VO1;
                    default: next_sel = TRB_IO1;
                endcase
            end
            default:        next_sel = TRB_DIE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_sel_o <= TRB_VIN;
            rr_r       <= 3'h0;
            srr_r      <= 2'h0;
        end else if (take) begin
            conv_sel_o <= next_sel;
            // Index follows the select so round robin resumes in order
            rr_r       <= next_sel;
            srr_r      <= (sel_r == `TRB_SEL_SHORT) ? srr_r + 2'd1 : 2'h3;
        end
    end

    // ----------------------------------------
    // Short loop ready flags
    // ----------------------------------------
    assign flag_hit[0] = (conv_sel_o == TRB_VO0);
    assign flag_hit[1] = (conv_sel_o == TRB_IO0);
    assign flag_hit[2] = (conv_sel_o == TRB_VO1);
    assign flag_hit[3] = (conv_sel_o == TRB_IO1);

    // Set wins over a same-cycle clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_o <= 4'h0;
        end else if (ce_i) begin
            for (int k = 0; k < 4; k++) begin
                if (take && sel_r == `TRB_SEL_SHORT && flag_hit[k]) begin
                    flags_o[k] <= 1'b1;
                end else if (flag_clr_i[k]) begin
                    flags_o[k] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Unpaged values and peaks
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            vin_r    <= 11'h000;
            vin_pk_r <= `TRB_L11_MIN;
        end else if (ce_i) begin
            if (take && conv_sel_o == TRB_VIN) begin
                vin_r <= conv_data_i[10:0];
            end
            if (take && conv_sel_o == TRB_VIN &&
                (peak_clr_i || $signed(conv_data_i[10:0]) > $signed(vin_pk_r))) begin
                vin_pk_r <= conv_data_i[10:0];
            end else if (peak_clr_i) begin
                vin_pk_r <= `TRB_L11_MIN;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            die_r    <= 11'h000;
            die_pk_r <= `TRB_L11_MIN;
        end else if (ce_i) begin
            if (take && conv_sel_o == TRB_DIE) begin
                die_r <= conv_data_i[10:0];
            end
            if (take && conv_sel_o == TRB_DIE &&
                (peak_clr_i || $signed(conv_data_i[10:0]) > $signed(die_pk_r))) begin
                die_pk_r <= conv_data_i[10:0];
            end else if (peak_clr_i) begin
                die_pk_r <= `TRB_L11_MIN;
            end
        end
    end

    // ----------------------------------------
    // Per-channel values
    // ----------------------------------------
    for (genvar c = 0; c < 2; c++) begin : g_ch
        trb_param_e p_v;
        trb_param_e p_i;
        trb_param_e p_t;
        logic [26:0] tprod;
        logic [27:0] tcprod;
        logic [15:0] geff;
        logic [27:0] iprod;
        logic [19:0] dprod;
        logic [27:0] pprod;
        logic        tk_v;
        logic        tk_i;
        logic        tk_t;

        assign p_v  = c ? TRB_VO1 : TRB_VO0;
        assign p_i  = c ? TRB_IO1 : TRB_IO0;
        assign p_t  = c ? TRB_TS1 : TRB_TS0;
        assign tk_v = take && conv_sel_o == p_v;
        assign tk_i = take && conv_sel_o == p_i;
        assign tk_t = take && conv_sel_o == p_t;

        assign tprod  = 27'($signed(conv_data_i[10:0]) * $signed({1'b0, temp_gain_i[c]}));
        assign temp_new[c] = 11'($signed(tprod) >>> `TRB_TEMP_SHIFT) + temp_off_i[c];
        assign tcprod = 28'($signed(gain_tc_i[c]) * $signed(temp_r[c] - `TRB_TEMP_REF));
        assign geff   = cs_gain_i[c] + 16'($signed(tcprod) >>> `TRB_TC_SHIFT);
        assign iprod  = 28'($signed(conv_data_i[11:0]) * $signed(geff));
        assign iout_new[c] = 11'($signed(iprod) >>> `TRB_IOUT_SHIFT);
        assign dprod  = 20'($signed(iout_r[c]) * $signed({1'b0, duty_r[c]}));
        assign iin_ch[c] = iin_off_i[c] + 11'($signed(dprod) >>> `TRB_DUTY_SHIFT);
        // Widened product keeps the full duty range
        assign duty_pct[c] = 7'((16'(duty_r[c]) * 16'(`TRB_DUTY_PCT)) >> `TRB_DUTY_SHIFT);
        assign pprod  = 28'($signed({1'b0, vcor_r[c]}) * $signed(icor_r[c]));
        assign pout_ch[c] = 11'($signed(pprod) >>> `TRB_POUT_SHIFT);

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                vout_r[c]    <= 16'h0000;
                vout_pk_r[c] <= 16'h0000;
            end else if (ce_i) begin
                if (tk_v) begin
                    vout_r[c] <= conv_data_i;
                end
                if (tk_v && (peak_clr_i || conv_data_i > vout_pk_r[c])) begin
                    vout_pk_r[c] <= conv_data_i;
                end else if (peak_clr_i) begin
                    vout_pk_r[c] <= 16'h0000;
                end
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                iout_r[c]    <= 11'h000;
                iout_pk_r[c] <= `TRB_L11_MIN;
                duty_r[c]    <= 8'h00;
                vcor_r[c]    <= 16'h0000;
                icor_r[c]    <= 11'h000;
            end else if (ce_i) begin
                if (tk_i) begin
                    iout_r[c] <= iout_new[c];
                    duty_r[c] <= duty_i[c];
                    vcor_r[c] <= vout_r[c];
                    icor_r[c] <= iout_new[c];
                end
                if (tk_i && (peak_clr_i || $signed(iout_new[c]) > $signed(iout_pk_r[c]))) begin
                    iout_pk_r[c] <= iout_new[c];
                end else if (peak_clr_i) begin
                    iout_pk_r[c] <= `TRB_L11_MIN;
                end
            end
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                temp_r[c]    <= 11'h000;
                temp_pk_r[c] <= `TRB_L11_MIN;
            end else if (ce_i) begin
                if (tk_t) begin
                    temp_r[c] <= temp_new[c];
                end
                if (tk_t && (peak_clr_i || $signed(temp_new[c]) > $signed(temp_pk_r[c]))) begin
                    temp_pk_r[c] <= temp_new[c];
                end else if (peak_clr_i) begin
                    temp_pk_r[c] <= `TRB_L11_MIN;
                end
            end
        end
    end

    assign iin_tot  = iin_ch[0] + iin_ch[1];
    assign pout_exp = vout_exp_i + `TRB_EXP_IOUT + `TRB_EXP_POUT_ADJ;

    // ----------------------------------------
    // Read multiplexer
    // ----------------------------------------
    always_comb begin
        known = 1'b1;
        unique case (cmd_i)
            `TRB_CMD_VIN:       word_nxt = {`TRB_EXP_VIN, vin_r};
            `TRB_CMD_IIN:       word_nxt = {`TRB_EXP_IOUT, iin_tot};
            `TRB_CMD_VOUT:      word_nxt = vout_r[page_i];
            `TRB_CMD_IOUT:      word_nxt = {`TRB_EXP_IOUT, iout_r[page_i]};
            `TRB_CMD_TSTAGE:    word_nxt = {`TRB_EXP_TEMP, temp_r[page_i]};
            `TRB_CMD_TDIE:      word_nxt = {`TRB_EXP_TEMP, die_r};
            `TRB_CMD_DUTY:      word_nxt = {`TRB_EXP_DUTY, 4'h0, duty_pct[page_i]};
            `TRB_CMD_POUT:      word_nxt = {pout_exp, pout_ch[page_i]};
            `TRB_CMD_IOUT_PK:   word_nxt = {`TRB_EXP_IOUT, iout_pk_r[page_i]};
            `TRB_CMD_SEL:       word_nxt = {8'h00, sel_r};
            `TRB_CMD_VOUT_PK:   word_nxt = vout_pk_r[page_i];
            `TRB_CMD_VIN_PK:    word_nxt = {`TRB_EXP_VIN, vin_pk_r};
            `TRB_CMD_TSTAGE_PK: word_nxt = {`TRB_EXP_TEMP, temp_pk_r[page_i]};
            `TRB_CMD_IIN_CH:    word_nxt = {`TRB_EXP_IOUT, iin_ch[page_i]};
            `TRB_CMD_TDIE_PK:   word_nxt = {`TRB_EXP_TEMP, die_pk_r};
            // Unknown codes read zero and raise the error flag
            default: begin
                word_nxt = 16'h0000;
                known    = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Byte delivery
    // ----------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            word_r    <= 16'h0000;
            hi_r      <= 1'b0;
            one_r     <= 1'b0;
            cmd_err_o <= 1'b0;
        end else if (ce_i && rd_start_i) begin
            word_r    <= word_nxt;
            hi_r      <= 1'b0;
            one_r     <= (cmd_i == `TRB_CMD_SEL);
            cmd_err_o <= ~known;
        end else if (ce_i && byte_rd_i) begin
            hi_r <= ~hi_r | one_r;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_byte_o <= 8'h00;
        end else if (ce_i && byte_rd_i && !rd_start_i) begin
            rd_byte_o <= hi_r ? (one_r ? 8'h00 : word_r[15:8]) : word_r[7:0];
        end
    end

endmodule : trb_telemetry_bank

/* File: tb/tb.sv */
// Testbench of the telemetry readback bank
`timescale 1ns/1ps
module tb;
    import trb_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             ce_i = 1'b1;
    logic             page_i = 1'b0;
    logic [7:0]       cmd_i = 8'h00;
    logic             rd_start_i = 1'b0;
    logic             byte_rd_i = 1'b0;
    logic             wr_byte_i = 1'b0;
    logic [7:0]       wr_data_i = 8'h00;
    logic             peak_clr_i = 1'b0;
    logic [3:0]       flag_clr_i = 4'h0;
    logic             conv_done_i;
    logic [15:0]      conv_data_i;
    logic [4:0]       vout_exp_i = 5'h14;
    logic [1:0][7:0]  duty_i = {8'h40, 8'h80};
    logic [1:0][15:0] cs_gain_i = {16'h1000, 16'h1000};
    logic [1:0][15:0] gain_tc_i = '0;
    logic [1:0][15:0] temp_gain_i = {16'h0400, 16'h0400};
    logic [1:0][10:0] temp_off_i = '0;
    logic [1:0][10:0] iin_off_i = {11'h003, 11'h005};
    trb_param_e       conv_sel_o;
    logic [7:0]       rd_byte_o;
    logic             cmd_err_o;
    logic [3:0]       flags_o;
    logic             cml_fault_o;
    logic             req = 1'b0;
    logic [7:0][15:0] vals = {16'h0020, 16'h0040, 16'h1800, 16'h0039, 16'h0100, 16'h3000, 16'h0045, 16'h0123};
    trb_param_e       sq [5] = '{TRB_VO0, TRB_IO0, TRB_VO1, TRB_IO1, TRB_VO0};
    logic [7:0]       codes [8] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0c};
    int               bad_count = 0;
    int               checks = 0;
    int               i;
    trb_telemetry_bank uut (.clk_i, .rst_i, .ce_i, .page_i, .cmd_i, .rd_start_i, .byte_rd_i, .wr_byte_i,
        .wr_data_i, .peak_clr_i, .flag_clr_i, .conv_done_i, .conv_data_i, .vout_exp_i, .duty_i, .cs_gain_i,
        .gain_tc_i, .temp_gain_i, .temp_off_i, .iin_off_i, .conv_sel_o, .rd_byte_o, .cmd_err_o, .flags_o,
        .cml_fault_o);
    trb_adc_model u_adc (.clk_i, .req_i(req), .sel_i(conv_sel_o), .vals_i(vals), .done_o(conv_done_i),
        .data_o(conv_data_i));
    always #10 clk_i = ~clk_i;
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic conv(input int n);
        @(negedge clk_i);
        req <= 1'b1;
        repeat (n) @(negedge clk_i);
        req <= 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : conv
    task automatic rc(input logic [7:0] c, input logic p, input logic [15:0] e, input string n);
        logic [15:0] w;
        @(negedge clk_i);
        cmd_i = c;
        page_i = p;
        rd_start_i = 1'b1;
        @(negedge clk_i);
        rd_start_i = 1'b0;
        byte_rd_i = 1'b1;
        @(negedge clk_i);
        w[7:0] = rd_byte_o;
        @(negedge clk_i);
        w[15:8] = rd_byte_o;
        byte_rd_i = 1'b0;
        chk(n, e, w);
    endtask : rc
    task automatic wr(input logic [7:0] d, input logic [7:0] c = 8'hd8);
        @(negedge clk_i);
        cmd_i = c;
        wr_data_i = d;
        wr_byte_i = 1'b1;
        @(negedge clk_i);
        wr_byte_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : wr
    task automatic close_out;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        rc(8'hd8, 1'b0, 16'h0000, "select reset");
        rc(8'h00, 1'b0, 16'h0000, "unknown code");
        chk("cmd error", 16'h0001, cmd_err_o);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            chk("round robin", i[15:0], conv_sel_o);
            conv(1);
        end
        rc(8'h88, 1'b0, 16'hd123, "input voltage");
        chk("cmd error clear", 16'h0000, cmd_err_o);
        rc(8'h8e, 1'b0, 16'h0045, "die temp");
        rc(8'h8b, 1'b0, 16'h3000, "vout ch0");
        rc(8'h8b, 1'b1, 16'h1800, "vout ch1");
        rc(8'h8c, 1'b0, 16'he100, "iout ch0");
        rc(8'h8c, 1'b1, 16'he040, "iout ch1");
        rc(8'h8d, 1'b0, 16'h0039, "stage temp");
        rc(8'h94, 1'b0, 16'h0032, "duty ch0");
        rc(8'h94, 1'b1, 16'h0019, "duty ch1");
        rc(8'h96, 1'b0, 16'h0030, "power");
        rc(8'hed, 1'b0, 16'he085, "iin ch0");
        rc(8'h89, 1'b0, 16'he098, "iin total");
        rc(8'hde, 1'b0, 16'hd123, "vin peak");
        rc(8'hdf, 1'b0, 16'h0039, "stage peak");
        rc(8'hf4, 1'b0, 16'h0045, "die peak");
        rc(8'hd7, 1'b0, 16'he100, "iout peak");
        $display("test readings done");
        gain_tc_i[0] = 16'h0400;
        vals[2] = 16'h2000;
        conv(8);
        rc(8'h8c, 1'b0, 16'he102, "iout tempco");
        rc(8'hdd, 1'b0, 16'h3000, "vout peak held");
        rc(8'h96, 1'b0, 16'h0020, "power pair");
        @(negedge clk_i);
        peak_clr_i = 1'b1;
        @(negedge clk_i);
        peak_clr_i = 1'b0;
        conv(8);
        rc(8'hdd, 1'b0, 16'h2000, "vout peak cleared");
        $display("test peaks done");
        wr(8'h0d);
        rc(8'hd8, 1'b0, 16'h000d, "select readback");
        for (i = 0; i < 5; i++) begin
            conv(1);
            chk("short loop", sq[i], conv_sel_o);
        end
        chk("ready flags", 16'h000f, flags_o);
        @(negedge clk_i);
        flag_clr_i = 4'hf;
        @(negedge clk_i);
        flag_clr_i = 4'h0;
        chk("flags cleared", 16'h0000, flags_o);
        wr(8'h01, 8'h88);
        rc(8'hd8, 1'b0, 16'h000d, "select kept");
        wr(8'h0e);
        chk("comm fault set", 16'h0001, cml_fault_o);
        conv(1);
        chk("die fallback", TRB_DIE, conv_sel_o);
        for (i = 0; i < 8; i++) begin
            wr(codes[i]);
            conv(1);
            chk("single code", i[15:0], conv_sel_o);
        end
        chk("comm fault clear", 16'h0000, cml_fault_o);
        ce_i = 1'b0;
        conv(1);
        chk("enable hold", TRB_TS1, conv_sel_o);
        ce_i = 1'b1;
        wr(8'h00);
        $display("test select done");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        close_out();
    end
endmodule : tb

/* File: tb/trb_adc_model.sv */
// Conversion source model feeding the telemetry bank
`timescale 1ns/1ps
module trb_adc_model (
    input  wire logic                clk_i,
    input  wire logic                req_i,
    input  wire trb_pkg::trb_param_e sel_i,
    input  wire logic [7:0][15:0]    vals_i,
    output logic                     done_o,
    output logic [15:0]              data_o
);
    import trb_pkg::*;
    initial begin
        done_o = 1'b0;
        data_o = 16'h0000;
    end
    // Result only valid with done; idle data toggles
    always @(negedge clk_i) begin
        done_o <= req_i;
        data_o <= req_i ? vals_i[sel_i] : ~data_o;
    end
endmodule : trb_adc_model

/* File: tb/trb_telemetry_bank_sva.sv */
// Assertion checker for the telemetry readback bank
`timescale 1ns/1ps
module trb_telemetry_bank_sva (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                ce_i,
    input wire logic [7:0]          cmd_i,
    input wire logic                rd_start_i,
    input wire logic                byte_rd_i,
    input wire logic                wr_byte_i,
    input wire logic [7:0]          wr_data_i,
    input wire logic                conv_done_i,
    input wire trb_pkg::trb_param_e conv_sel_o,
    input wire logic [7:0]          rd_byte_o,
    input wire logic                cmd_err_o,
    input wire logic [3:0]          flags_o,
    input wire logic                cml_fault_o
);
    import trb_pkg::*;
    logic [7:0] sel_r;
    wire logic  wr_sel = ce_i && wr_byte_i && cmd_i == 8'hd8;
    wire logic  done = ce_i && conv_done_i;
    function automatic logic rsv(input logic [7:0] v);
        return !(v inside {8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0d});
    endfunction : rsv
    // Shadow of the select byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) sel_r <= 8'h00;
        else if (wr_sel) sel_r <= wr_data_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_RST_VAL: assert property ($fell(rst_i) |-> conv_sel_o == TRB_VIN && flags_o == 4'h0 && !cml_fault_o)
        else $error("state after reset wrong");
    AST_RR_STEP: assert property (done && sel_r == 8'h00 |=> conv_sel_o == 3'($past(conv_sel_o) + 3'h1))
        else $error("round robin step wrong");
    AST_SEL_HOLD: assert property (!done |=> $stable(conv_sel_o))
        else $error("conversion select moved without done");
    AST_DIE_FALLBACK: assert property (done && rsv(sel_r) |=> conv_sel_o == TRB_DIE)
        else $error("reserved select not on die temperature");
    AST_CML_SET: assert property (wr_sel && rsv(wr_data_i) |-> ##2 cml_fault_o)
        else $error("comm fault not raised");
    AST_CML_CLR: assert property (wr_sel && !rsv(wr_data_i) |-> ##2 !cml_fault_o)
        else $error("comm fault not dropped");
    AST_FLAG_SET: assert property (done && sel_r == 8'h0d && conv_sel_o == TRB_VO0 |=> flags_o[0])
        else $error("ready flag not set");
    AST_BYTE_HOLD: assert property (!(ce_i && byte_rd_i) |=> $stable(rd_byte_o))
        else $error("read byte changed without request");
    AST_SEL_READ: assert property (ce_i && rd_start_i && cmd_i == 8'hd8 ##1 ce_i && byte_rd_i && !rd_start_i
        |=> rd_byte_o == sel_r)
        else $error("select readback wrong");
    AST_VIN_OK: assert property (ce_i && rd_start_i && cmd_i == 8'h88 |=> !cmd_err_o)
        else $error("input voltage code refused");
    cover property (done && sel_r == 8'h0d);
    cover property (cml_fault_o);
    cover property (ce_i && rd_start_i && cmd_i == 8'h96);
endmodule : trb_telemetry_bank_sva
bind trb_telemetry_bank trb_telemetry_bank_sva u_sva (.clk_i, .rst_i, .ce_i, .cmd_i, .rd_start_i, .byte_rd_i,
    .wr_byte_i, .wr_data_i, .conv_done_i, .conv_sel_o, .rd_byte_o, .cmd_err_o, .flags_o, .cml_fault_o);
